// *** verilog/cfv_regs.sv ***
// register bank: fault status, input voltage limit control, thermal flag and battery voltage
`timescale 1ns/1ns
module cfv_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cfv_pkg::cfv_req_t req_i,
    input wire cfv_pkg::cfv_cond_t cond_i,
    input wire logic [6:0] relative_limit_code_i,
    input wire logic relative_limit_update_i,
    input wire logic [6:0] battery_voltage_code_i,
    input wire logic battery_voltage_valid_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [6:0] input_voltage_limit_code_o,
    output logic input_limit_absolute_select_o
);
    // -------------------------------------------------------------------------
    // input synchronisation
    // -------------------------------------------------------------------------
    cfv_pkg::cfv_cond_t cond_s;

    cfv_sync #(
        .WIDTH($bits(cfv_pkg::cfv_cond_t))
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(cond_i),
        .q_o(cond_s)
    );

    // -------------------------------------------------------------------------
    // status encoding
    // -------------------------------------------------------------------------
    cfv_pkg::cfv_charge_fault_t charge_fault_code;
    logic [2:0] thermistor_fault_code;

    wire logic boost_fault_w = cond_s.boost_overload | cond_s.boost_overvoltage
        | cond_s.boost_battery_low;
    wire logic input_fault_w = cond_s.input_overvoltage | cond_s.input_undervoltage;

    // input fault outranks thermal, which outranks the timer
    assign charge_fault_code = input_fault_w ? cfv_pkg::CHG_INPUT :
        cond_s.thermal_shutdown ? cfv_pkg::CHG_THERMAL :
        cond_s.safety_timer_expired ? cfv_pkg::CHG_TIMER : cfv_pkg::CHG_NORMAL;

    // cold wins when both sense lines disagree with reality
    wire logic [2:0] buck_ntc_w = cond_s.thermistor_cold ? cfv_pkg::NTC_BUCK_COLD :
        cond_s.thermistor_hot ? cfv_pkg::NTC_BUCK_HOT : cfv_pkg::NTC_NORMAL;
    wire logic [2:0] boost_ntc_w = cond_s.thermistor_cold ? cfv_pkg::NTC_BOOST_COLD :
        cond_s.thermistor_hot ? cfv_pkg::NTC_BOOST_HOT : cfv_pkg::NTC_NORMAL;
    assign thermistor_fault_code = cond_s.boost_mode ? boost_ntc_w : buck_ntc_w;

    wire logic [7:0] fault_status_w = {
        cond_s.watchdog_expired,
        boost_fault_w,
        charge_fault_code,
        cond_s.battery_overvoltage,
        thermistor_fault_code
    };

    // -------------------------------------------------------------------------
    // input voltage limit control
    // -------------------------------------------------------------------------
    logic abs_select_reg;
    logic abs_select_next;
    logic [6:0] limit_code_reg;
    logic [6:0] limit_code_next;
    logic [6:0] battery_voltage_reg;
    logic [6:0] battery_voltage_next;

    wire logic wr_limit_w = req_i.wr_en & (req_i.addr == cfv_pkg::VIN_LIMIT_ADDR);
    wire logic [6:0] host_code_w = req_i.wdata[6:0];
    wire logic [6:0] rel_code_w = relative_limit_code_i;
    wire logic [6:0] host_clamped_w = (host_code_w < cfv_pkg::VIN_LIMIT_MIN) ?
        cfv_pkg::VIN_LIMIT_MIN : host_code_w;
    wire logic [6:0] rel_clamped_w = (rel_code_w < cfv_pkg::VIN_LIMIT_MIN) ?
        cfv_pkg::VIN_LIMIT_MIN : rel_code_w;

    // the select bit is always writable; the code follows the mode in force before the write
    assign abs_select_next = wr_limit_w ? req_i.wdata[cfv_pkg::ABS_SELECT_BIT] :
        abs_select_reg;
    assign limit_code_next = (abs_select_reg && wr_limit_w) ? host_clamped_w :
        (!abs_select_reg && relative_limit_update_i) ? rel_clamped_w :
        limit_code_reg;
    assign battery_voltage_next = battery_voltage_valid_i ? battery_voltage_code_i :
        battery_voltage_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            abs_select_reg <= cfv_pkg::VIN_ABS_RESET;
            limit_code_reg <= cfv_pkg::VIN_LIMIT_RESET;
            battery_voltage_reg <= cfv_pkg::BATTERY_VOLTAGE_CODE_RESET;
        end else begin
            abs_select_reg <= abs_select_next;
            limit_code_reg <= limit_code_next;
            battery_voltage_reg <= battery_voltage_next;
        end
    end

    // -------------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;

    wire logic [7:0] limit_read_w = {abs_select_reg, limit_code_reg};
    wire logic [7:0] therm_battery_voltage_code_w = {cond_s.thermal_regulation, battery_voltage_reg};

    // unmapped addresses read as zero
    assign rdata_next = !req_i.rd_en ? rdata_reg :
        (req_i.addr == cfv_pkg::FAULT_STATUS_ADDR) ? fault_status_w :
        (req_i.addr == cfv_pkg::VIN_LIMIT_ADDR) ? limit_read_w :
        (req_i.addr == cfv_pkg::THERM_BATTERY_VOLTAGE_CODE_ADDR) ? therm_battery_voltage_code_w : 8'h00;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= req_i.rd_en;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign input_voltage_limit_code_o = limit_code_reg;
    assign input_limit_absolute_select_o = abs_select_reg;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    property p_watchdog;
        @(posedge clk_i) disable iff (rst_i)
        req_i.rd_en && req_i.addr == cfv_pkg::FAULT_STATUS_ADDR
        |=> rdata_o[cfv_pkg::WATCHDOG_BIT] == $past(cond_s.watchdog_expired);
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog bit wrong");

    property p_boost;
        @(posedge clk_i) disable iff (rst_i)
        req_i.rd_en && req_i.addr == cfv_pkg::FAULT_STATUS_ADDR
        |=> rdata_o[cfv_pkg::BOOST_FAULT_BIT] == $past(boost_fault_w);
    endproperty
    a_boost: assert property (p_boost) else $error("boost fault bit wrong");

    property p_charge;
        @(posedge clk_i) disable iff (rst_i)
        input_fault_w |-> charge_fault_code == cfv_pkg::CHG_INPUT;
    endproperty
    a_charge: assert property (p_charge) else $error("input fault not reported");

    property p_batov;
        @(posedge clk_i) disable iff (rst_i)
        req_i.rd_en && req_i.addr == cfv_pkg::FAULT_STATUS_ADDR
        |=> rdata_o[cfv_pkg::BATTERY_OV_BIT] == $past(cond_s.battery_overvoltage);
    endproperty
    a_batov: assert property (p_batov) else $error("battery fault bit wrong");

    property p_ntc_buck;
        @(posedge clk_i) disable iff (rst_i)
        !cond_s.boost_mode && cond_s.thermistor_cold
        |-> thermistor_fault_code == cfv_pkg::NTC_BUCK_COLD;
    endproperty
    a_ntc_buck: assert property (p_ntc_buck) else $error("buck cold code wrong");

    property p_ntc_boost;
        @(posedge clk_i) disable iff (rst_i)
        cond_s.boost_mode && !cond_s.thermistor_cold && cond_s.thermistor_hot
        |-> thermistor_fault_code == cfv_pkg::NTC_BOOST_HOT;
    endproperty
    a_ntc_boost: assert property (p_ntc_boost) else $error("boost hot code wrong");

    property p_select;
        @(posedge clk_i) disable iff (rst_i)
        wr_limit_w |=> input_limit_absolute_select_o == $past(req_i.wdata[7]);
    endproperty
    a_select: assert property (p_select) else $error("select bit not stored");

    property p_clamp;
        @(posedge clk_i) disable iff (rst_i)
        input_voltage_limit_code_o >= cfv_pkg::VIN_LIMIT_MIN;
    endproperty
    a_clamp: assert property (p_clamp) else $error("limit code below minimum");

    property p_ignore;
        @(posedge clk_i) disable iff (rst_i)
        !abs_select_reg && !relative_limit_update_i |=> $stable(limit_code_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("relative mode code moved");

    property p_therm;
        @(posedge clk_i) disable iff (rst_i)
        req_i.rd_en && req_i.addr == cfv_pkg::THERM_BATTERY_VOLTAGE_CODE_ADDR
        |=> rdata_o == {$past(cond_s.thermal_regulation), $past(battery_voltage_reg)};
    endproperty
    a_therm: assert property (p_therm) else $error("thermal or battery read wrong");

    c_abs_write: cover property (@(posedge clk_i) disable iff (rst_i)
        abs_select_reg && wr_limit_w);
    c_rel_update: cover property (@(posedge clk_i) disable iff (rst_i)
        !abs_select_reg && relative_limit_update_i);
    c_boost_cold: cover property (@(posedge clk_i) disable iff (rst_i)
        thermistor_fault_code == cfv_pkg::NTC_BOOST_COLD);
endmodule : cfv_regs

// *** verilog/cfv_pkg.sv ***
// package: register map, field layout and encodings of the charger fault / input limit slice
package cfv_pkg;

    // -------------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] FAULT_STATUS_ADDR = 8'h0c;
    localparam logic [7:0] VIN_LIMIT_ADDR = 8'h0d;
    localparam logic [7:0] THERM_BATTERY_VOLTAGE_CODE_ADDR = 8'h0e;

    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int WATCHDOG_BIT = 7;
    localparam int BOOST_FAULT_BIT = 6;
    localparam int CHARGE_FAULT_LSB = 4;
    localparam int BATTERY_OV_BIT = 3;
    localparam int THERMISTOR_LSB = 0;
    localparam int ABS_SELECT_BIT = 7;
    localparam int THERMAL_REG_BIT = 7;

    // -------------------------------------------------------------------------
    // reset values and limits
    // -------------------------------------------------------------------------
    localparam logic [6:0] VIN_LIMIT_RESET = 7'h12;
    localparam logic [6:0] VIN_LIMIT_MIN = 7'h0d;
    localparam logic VIN_ABS_RESET = 1'b0;
    localparam logic [6:0] BATTERY_VOLTAGE_CODE_RESET = 7'h00;

    // scale: limit = 2600 mV + 100 mV per step; battery = 2304 mV + 20 mV per step
    localparam int VIN_OFFSET_MV = 2600;
    localparam int VIN_STEP_MV = 100;
    localparam int BATTERY_VOLTAGE_CODE_OFFSET_MV = 2304;
    localparam int BATTERY_VOLTAGE_CODE_STEP_MV = 20;

    // -------------------------------------------------------------------------
    // encodings
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CHG_NORMAL = 2'b00,
        CHG_INPUT = 2'b01,
        CHG_THERMAL = 2'b10,
        CHG_TIMER = 2'b11
    } cfv_charge_fault_t;

    localparam logic [2:0] NTC_NORMAL = 3'b000;
    localparam logic [2:0] NTC_BUCK_COLD = 3'b001;
    localparam logic [2:0] NTC_BUCK_HOT = 3'b010;
    localparam logic [2:0] NTC_BOOST_COLD = 3'b101;
    localparam logic [2:0] NTC_BOOST_HOT = 3'b110;

    // raw conditions from the analog side
    typedef struct packed {
        logic watchdog_expired;
        logic boost_overload;
        logic boost_overvoltage;
        logic boost_battery_low;
        logic input_overvoltage;
        logic input_undervoltage;
        logic thermal_shutdown;
        logic safety_timer_expired;
        logic battery_overvoltage;
        logic boost_mode;
        logic thermistor_cold;
        logic thermistor_hot;
        logic thermal_regulation;
    } cfv_cond_t;

    // host register port
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfv_req_t;

endpackage : cfv_pkg

// *** verilog/cfv_sync.sv ***
// three-stage synchroniser for pin-level inputs; change taken when stages two and three agree
`timescale 1ns/1ns
module cfv_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;
    wire logic [WIDTH-1:0] agree_w = ~(s2_reg ^ s3_reg);
    wire logic [WIDTH-1:0] q_next = (agree_w & s3_reg) | (~agree_w & q_reg);

    if (WIDTH < 1) begin : g_chk
        $error("cfv_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule : cfv_sync

// *** testbench/cfv_analog_model.sv ***
// analog-side model: turns a numbered condition scenario into the raw condition levels
`timescale 1ns/1ns
module cfv_analog_model (
    input wire logic [3:0] scen_i,
    output cfv_pkg::cfv_cond_t cond_o
);
    // -------------------------------------------------------------------------
    // scenario decode
    // -------------------------------------------------------------------------
    // one condition at a time, bar boost_mode with cold or hot in 4'hc and 4'hd, so each field is seen without priority effects
    always_comb begin
        cond_o = '0;
        case (scen_i)
            4'h1: cond_o.watchdog_expired = 1'b1;
            4'h2: cond_o.boost_overload = 1'b1;
            4'h3: cond_o.boost_overvoltage = 1'b1;
            4'h4: cond_o.boost_battery_low = 1'b1;
            4'h5: cond_o.input_overvoltage = 1'b1;
            4'h6: cond_o.input_undervoltage = 1'b1;
            4'h7: cond_o.thermal_shutdown = 1'b1;
            4'h8: cond_o.safety_timer_expired = 1'b1;
            4'h9: cond_o.battery_overvoltage = 1'b1;
            4'ha: cond_o.thermistor_cold = 1'b1;
            4'hb: cond_o.thermistor_hot = 1'b1;
            4'hc: cond_o = {10'h001, 3'b100};
            4'hd: cond_o = {10'h001, 3'b010};
            4'he: cond_o.thermal_regulation = 1'b1;
            default: cond_o = '0;
        endcase
    end
endmodule : cfv_analog_model

// *** testbench/cfv_regs_tb.sv ***
// testbench: host register traffic against the fault / input limit register slice
`timescale 1ns/1ns
module cfv_regs_tb;
    logic clk_i;
    logic rst_i;
    cfv_pkg::cfv_req_t req;
    cfv_pkg::cfv_cond_t cond;
    logic [3:0] scen;
    logic [6:0] rel_code;
    logic rel_upd;
    logic [6:0] bat_code;
    logic bat_vld;
    logic [7:0] rdata;
    logic rvalid;
    logic [6:0] lim_code;
    logic abs_sel;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] fault_exp [15];

    cfv_analog_model cfv_analog_model_inst (.scen_i(scen), .cond_o(cond));
    cfv_regs cfv_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .cond_i(cond),
        .relative_limit_code_i(rel_code), .relative_limit_update_i(rel_upd),
        .battery_voltage_code_i(bat_code), .battery_voltage_valid_i(bat_vld),
        .rdata_o(rdata), .rvalid_o(rvalid), .input_voltage_limit_code_o(lim_code),
        .input_limit_absolute_select_o(abs_sel));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req <= '0;
        @(posedge clk_i);
    endtask : wr

    // rvalid stands only for the cycle after the read edge and drops at the next edge,
    // so it is sampled mid-cycle, before that edge can clear it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_i);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        req <= '0;
        @(negedge clk_i);
        chk({name, " rvalid"}, 8'h01, {7'h00, rvalid});
        chk(name, exp, rdata);
    endtask : rd

    task automatic rel(input logic [6:0] c);
        @(posedge clk_i);
        rel_code <= c;
        rel_upd <= 1'b1;
        @(posedge clk_i);
        rel_upd <= 1'b0;
        @(posedge clk_i);
    endtask : rel

    task automatic bat(input logic [6:0] c);
        @(posedge clk_i);
        bat_code <= c;
        bat_vld <= 1'b1;
        @(posedge clk_i);
        bat_vld <= 1'b0;
        @(posedge clk_i);
    endtask : bat

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        fault_exp = '{8'h00, 8'h80, 8'h40, 8'h40, 8'h40, 8'h10, 8'h10, 8'h20,
            8'h30, 8'h08, 8'h01, 8'h02, 8'h05, 8'h06, 8'h00};
        rst_i = 1'b1;
        req = '0;
        scen = 4'h0;
        rel_code = 7'h00;
        rel_upd = 1'b0;
        bat_code = 7'h00;
        bat_vld = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0d, 8'h12, "limit reset");
        rd(8'h0e, 8'h00, "therm battery_voltage_code reset");
        rd(8'h0c, 8'h00, "fault reset");
        rd(8'h0f, 8'h00, "unmapped");
        $display("test reset done");
        wr(8'h0d, 8'h33);
        rd(8'h0d, 8'h12, "relative write ignored");
        rel(7'h20);
        rd(8'h0d, 8'h20, "relative update");
        rel(7'h05);
        rd(8'h0d, 8'h0d, "relative clamp");
        $display("test relative done");
        wr(8'h0d, 8'h80);
        rd(8'h0d, 8'h8d, "absolute select");
        chk("select port", 8'h01, {7'h00, abs_sel});
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'hff, "top code");
        wr(8'h0d, 8'h8c);
        rd(8'h0d, 8'h8d, "below min clamp");
        chk("code port", 8'h0d, {1'b0, lim_code});
        wr(8'h0d, 8'h8e);
        rel(7'h30);
        rd(8'h0d, 8'h8e, "update ignored in absolute");
        wr(8'h0d, 8'h00);
        rd(8'h0d, 8'h0d, "back to relative");
        // mid-run reset must bring the code back from a host-changed value
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h0d, 8'h12, "limit after reset");
        chk("code port reset", 8'h12, {1'b0, lim_code});
        $display("test absolute done");
        wr(8'h0c, 8'hff);
        wr(8'h0e, 8'hff);
        rd(8'h0c, 8'h00, "fault read only");
        rd(8'h0e, 8'h00, "battery_voltage_code read only");
        bat(7'h7f);
        rd(8'h0e, 8'h7f, "battery_voltage_code full scale");
        bat(7'h55);
        rd(8'h0e, 8'h55, "battery_voltage_code pattern");
        $display("test battery done");
        for (int i = 1; i < 15; i++) begin
            @(posedge clk_i);
            scen <= i[3:0];
            repeat (6) @(posedge clk_i);
            rd(8'h0c, fault_exp[i], "fault code");
        end
        rd(8'h0e, 8'hd5, "thermal regulation");
        @(posedge clk_i);
        scen <= 4'h0;
        repeat (6) @(posedge clk_i);
        rd(8'h0e, 8'h55, "thermal cleared");
        rd(8'h0c, 8'h00, "faults cleared");
        $display("test conditions done");
        conclude();
    end
endmodule : cfv_regs_tb
